// File: design/zeb_external_interface.sv
module zeb_external_interface (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic timing_clock_full_in,
  input wire logic output_clock_divide_select_in,
  input wire logic clock_output_disable_in,
  input wire logic write_buffer_enable_in,
  input wire logic [1:0] write_buffer_depth_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::LW-1:0] zone_rd_lead_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::ACW-1:0] zone_rd_active_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::TW-1:0] zone_rd_trail_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::LW-1:0] zone_wr_lead_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::ACW-1:0] zone_wr_active_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::TW-1:0] zone_wr_trail_in,
  input wire logic [zeb_pkg::ZONES-1:0] zone_timing_doubler_in,
  input wire logic [zeb_pkg::ZONES-1:0] zone_use_ready_in,
  input wire logic [zeb_pkg::ZONES-1:0] zone_ready_sync_in,
  input wire logic [zeb_pkg::ZONES*zeb_pkg::ZW-1:0] zone_width_select_in,
  input wire logic [1:0] bank_zone_in,
  input wire logic [2:0] bank_cycles_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [1:0] req_zone_in,
  input wire logic req_write_in,
  input wire logic req_size32_in,
  input wire logic [zeb_pkg::AW-1:0] req_addr_in,
  input wire logic [zeb_pkg::DW-1:0] req_wdata_in,
  output logic rd_valid_out,
  output logic [zeb_pkg::DW-1:0] rd_data_out,
  output logic external_clock_output_out,
  output logic external_clock_output_oe_out,
  output logic [zeb_pkg::ZONES-1:0] zone_cs_n_out,
  output logic read_strobe_n_out,
  output logic low_write_strobe_n_out,
  output logic high_write_strobe_n_out,
  output logic [zeb_pkg::AW-1:0] external_address_bus_out,
  output logic [zeb_pkg::DW-1:0] external_data_bus_out,
  output logic external_data_bus_oe_out,
  input wire logic [zeb_pkg::DW-1:0] external_data_bus_in,
  input wire logic external_ready_in
);
  zeb_pkg::zeb_state_t s, n;
  zeb_pkg::zeb_req_t sel, req;
  logic [2:0] tper, per;
  logic [1:0] pcn, lim, wr_idx;
  logic tick, xr, pop, acc, dbl, use_c, hold, bnk;
  logic [zeb_pkg::LW-1:0] lead_v;
  logic [zeb_pkg::ACW-1:0] act_v;
  logic [zeb_pkg::TW-1:0] trl_v;
  logic [zeb_pkg::CW-1:0] llen, alen, tlen, pt, first_rem;
  zeb_pkg::zeb_st_t first_st;
  function automatic logic [1:0] inc3(input logic [1:0] v);
    inc3 = (v == zeb_pkg::WB_LAST) ? 2'h0 : v + 2'h1;
  endfunction
  // clock divider: system clock periods per external clock period
  // timing clock rate
  assign tper = timing_clock_full_in ? zeb_pkg::PER_FULL : zeb_pkg::PER_HALF;
  assign per = output_clock_divide_select_in ? tper : {tper[1:0], 1'b0};
  assign pcn = ({1'b0, s.pc} + 3'h1 >= per) ? 2'h0 : s.pc + 2'h1;
  assign tick = timing_clock_full_in | ~pcn[0];
  // start only on external clock rise
  assign xr = (pcn == 2'h0);
  // request intake
  assign req = '{zone: req_zone_in, wr: req_write_in, sz32: req_size32_in,
    addr: req_addr_in, data: req_wdata_in};
  assign lim = (write_buffer_depth_in == 2'h0) ? 2'h1 : write_buffer_depth_in;
  // buffered writes accepted while room remains
  assign req_ready_out = (req_write_in && write_buffer_enable_in) ? (s.cnt < lim) :
    (s.cnt == 2'h0 && s.st == zeb_pkg::ST_IDLE);
  assign acc = req_valid_in && req_ready_out;
  assign wr_idx = (s.cnt == 2'h0) ? s.head :
    (s.cnt == 2'h1) ? inc3(s.head) : inc3(inc3(s.head));
  assign pop = (s.st == zeb_pkg::ST_IDLE) && xr && (s.cnt != 2'h0);
  // phase lengths of the access in hand (fifo head when idle); config not latched meanwhile
  // config read live during access
  assign sel = (s.st == zeb_pkg::ST_IDLE) ? s.fifo[s.head] : s.cur;
  assign lead_v = sel.wr ? zone_wr_lead_in[sel.zone*zeb_pkg::LW +: zeb_pkg::LW] :
    zone_rd_lead_in[sel.zone*zeb_pkg::LW +: zeb_pkg::LW];
  assign act_v = sel.wr ? zone_wr_active_in[sel.zone*zeb_pkg::ACW +: zeb_pkg::ACW] :
    zone_rd_active_in[sel.zone*zeb_pkg::ACW +: zeb_pkg::ACW];
  assign trl_v = sel.wr ? zone_wr_trail_in[sel.zone*zeb_pkg::TW +: zeb_pkg::TW] :
    zone_rd_trail_in[sel.zone*zeb_pkg::TW +: zeb_pkg::TW];
  assign dbl = zone_timing_doubler_in[sel.zone];
  assign llen = zeb_pkg::CW'(lead_v) << dbl;
  assign alen = (zeb_pkg::CW'(act_v) << dbl) + zeb_pkg::ACT_BASE;
  assign tlen = zeb_pkg::CW'(trl_v) << dbl;
  assign first_st = (llen == '0) ? zeb_pkg::ST_ACT : zeb_pkg::ST_LEAD;
  assign first_rem = (llen == '0) ? alen : llen;
  // ready sample point, clamped when active is shorter than it
  // per-zone use and mode
  assign use_c = zone_use_ready_in[sel.zone];
  assign pt = zone_ready_sync_in[sel.zone] ? zeb_pkg::SYNC_PT :
    ((alen < zeb_pkg::ASYNC_PT) ? alen : zeb_pkg::ASYNC_PT);
  assign hold = (s.st == zeb_pkg::ST_ACT) && tick && use_c && (s.rem == pt) && !s.rdy2;
  assign bnk = s.last_ok && (sel.zone != s.last_zone) && (bank_cycles_in != 3'h0) &&
    (sel.zone == bank_zone_in || s.last_zone == bank_zone_in);
  // next state: divider, fifo, access sequencer, pin images
  always_comb begin
    logic [1:0] zw;
    logic wact;
    zw = '0;
    wact = 1'b0;
    n = s;
    n.pc = pcn;
    n.rdy1 = external_ready_in;
    n.rdy2 = s.rdy1;
    n.din1 = external_data_bus_in;
    n.din2 = s.din1;
    n.rvalid = 1'b0;
    if (acc) begin
      n.fifo[wr_idx] = req;
    end
    n.cnt = s.cnt + {1'b0, acc} - {1'b0, pop};
    case (s.st)
      zeb_pkg::ST_IDLE: begin
        if (pop) begin
          n.cur = s.fifo[s.head];
          n.head = inc3(s.head);
          if (bnk) begin
            n.st = zeb_pkg::ST_BANK;
            n.rem = zeb_pkg::CW'(bank_cycles_in);
          end else begin
            n.st = first_st;
            n.rem = first_rem;
          end
        end
      end
      zeb_pkg::ST_BANK: begin
        if (tick) begin
          if (s.rem == zeb_pkg::CNT_ONE) begin
            n.st = first_st;
            n.rem = first_rem;
          end else begin
            n.rem = s.rem - zeb_pkg::CNT_ONE;
          end
        end
      end
      zeb_pkg::ST_LEAD: begin
        if (tick) begin
          if (s.rem == zeb_pkg::CNT_ONE) begin
            n.st = zeb_pkg::ST_ACT;
            n.rem = alen;
          end else begin
            n.rem = s.rem - zeb_pkg::CNT_ONE;
          end
        end
      end
      zeb_pkg::ST_ACT: begin
        if (tick && !hold) begin
          if (s.rem == zeb_pkg::CNT_ONE) begin
            if (zone_width_select_in[s.cur.zone*zeb_pkg::ZW +: zeb_pkg::ZW] ==
                zeb_pkg::WIDTH_32) begin
              n.rdata = s.din2;
            end else begin
              n.rdata = {{zeb_pkg::HW{1'b0}}, s.din2[zeb_pkg::HW-1:0]};
            end
            n.rvalid = !s.cur.wr;
            if (tlen == '0) begin
              n.st = zeb_pkg::ST_IDLE;
              n.last_zone = s.cur.zone;
              n.last_ok = 1'b1;
            end else begin
              n.st = zeb_pkg::ST_TRAIL;
              n.rem = tlen;
            end
          end else begin
            n.rem = s.rem - zeb_pkg::CNT_ONE;
          end
        end
      end
      zeb_pkg::ST_TRAIL: begin
        if (tick) begin
          if (s.rem == zeb_pkg::CNT_ONE) begin
            n.st = zeb_pkg::ST_IDLE;
            n.last_zone = s.cur.zone;
            n.last_ok = 1'b1;
          end else begin
            n.rem = s.rem - zeb_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        n.st = zeb_pkg::ST_IDLE;
      end
    endcase
    n.cs_n = '1;
    if (n.st == zeb_pkg::ST_LEAD || n.st == zeb_pkg::ST_ACT || n.st == zeb_pkg::ST_TRAIL) begin
      n.cs_n[n.cur.zone] = 1'b0;
    end
    n.rd_n = !(n.st == zeb_pkg::ST_ACT && !n.cur.wr);
    wact = (n.st == zeb_pkg::ST_ACT) && n.cur.wr;
    zw = zone_width_select_in[n.cur.zone*zeb_pkg::ZW +: zeb_pkg::ZW];
    if (zw == zeb_pkg::WIDTH_32) begin
      n.we0_n = !(wact && (n.cur.sz32 || !n.cur.addr[0]));
      n.we1_n = !(wact && (n.cur.sz32 || n.cur.addr[0]));
    end else begin
      n.we0_n = !wact;
      n.we1_n = 1'b1;
    end
    n.doe = wact;
    n.xclk = (per == zeb_pkg::PER_FULL) || ({1'b0, pcn} < {1'b0, per[2:1]});
    n.ckoe = !clock_output_disable_in;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s <= zeb_pkg::ZEB_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state flops
  assign rd_valid_out = s.rvalid;
  assign rd_data_out = s.rdata;
  assign external_clock_output_out = s.xclk;
  assign external_clock_output_oe_out = s.ckoe;
  assign zone_cs_n_out = s.cs_n;
  assign read_strobe_n_out = s.rd_n;
  assign low_write_strobe_n_out = s.we0_n;
  assign high_write_strobe_n_out = s.we1_n;
  assign external_address_bus_out = s.cur.addr;
  assign external_data_bus_out = s.cur.data;
  assign external_data_bus_oe_out = s.doe;
  // helper: timing ticks spent in active
  logic [zeb_pkg::CW:0] act_ticks;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || s.st != zeb_pkg::ST_ACT) begin
      act_ticks <= '0;
    end else if (tick) begin
      act_ticks <= act_ticks + 6'h01;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence sq_half_cfg;
    !timing_clock_full_in && !output_clock_divide_select_in;
  endsequence
  sequence sq_act_end;
    s.st == zeb_pkg::ST_ACT && tick && !hold && s.rem == zeb_pkg::CNT_ONE;
  endsequence
  sequence sq_start;
    $past(s.st) == zeb_pkg::ST_IDLE && s.st != zeb_pkg::ST_IDLE;
  endsequence

  AST_TIM_HALF: assert property (
    !timing_clock_full_in && tick |=> !tick || timing_clock_full_in)
    else $error("timing clock ticked twice in half mode");
  AST_START_RISE: assert property (
    sq_start |-> s.pc == 2'h0 && external_clock_output_out)
    else $error("access did not start on clock rise");
  AST_XCLK_QTR: assert property (
    ($rose(external_clock_output_out) and sq_half_cfg) ##1 sq_half_cfg [*3]
    |=> $rose(external_clock_output_out))
    else $error("external clock not a quarter of system clock");
  AST_CLOCK_OUTPUT_DISABLE: assert property (
    clock_output_disable_in |=> !external_clock_output_oe_out)
    else $error("clock pin driven while disabled");
  AST_LEAD_PINS: assert property (
    s.st == zeb_pkg::ST_LEAD |-> !zone_cs_n_out[s.cur.zone] && read_strobe_n_out &&
      low_write_strobe_n_out && external_address_bus_out == s.cur.addr)
    else $error("lead phase pins wrong");
  AST_ACT_LEN: assert property (
    sq_act_end ##0 !use_c |-> act_ticks + 6'h01 == {1'b0, alen})
    else $error("active phase length wrong");
  AST_RDY_EXT: assert property (
    hold |=> s.st == zeb_pkg::ST_ACT && $stable(s.rem))
    else $error("low ready did not extend active");
  AST_TRAIL_PINS: assert property (
    s.st == zeb_pkg::ST_TRAIL |-> !zone_cs_n_out[s.cur.zone] && read_strobe_n_out &&
      low_write_strobe_n_out && high_write_strobe_n_out)
    else $error("trail phase pins wrong");
  AST_BANK: assert property (
    pop && bnk |=> s.st == zeb_pkg::ST_BANK && &zone_cs_n_out)
    else $error("bank turnaround skipped");
  AST_WE16: assert property (
    zone_width_select_in[s.cur.zone*zeb_pkg::ZW +: zeb_pkg::ZW] == zeb_pkg::WIDTH_16 &&
      $stable(s.cur) |-> high_write_strobe_n_out)
    else $error("high strobe used in 16-bit mode");
  AST_WE32: assert property (
    s.st == zeb_pkg::ST_ACT && s.cur.wr && s.cur.sz32 && $stable(zone_width_select_in) &&
      zone_width_select_in[s.cur.zone*zeb_pkg::ZW +: zeb_pkg::ZW] == zeb_pkg::WIDTH_32
      |-> !low_write_strobe_n_out && !high_write_strobe_n_out)
    else $error("32-bit write strobes wrong");
  AST_IDLE_HIGH: assert property (
    s.st == zeb_pkg::ST_IDLE |-> &zone_cs_n_out && read_strobe_n_out &&
      low_write_strobe_n_out && high_write_strobe_n_out && !external_data_bus_oe_out)
    else $error("pins active between accesses");
endmodule // zeb_external_interface

// File: design/zeb_pkg.sv
package zeb_pkg;
  localparam int ZONES = 3;
  localparam int WBD = 3;
  localparam int AW = 20;
  localparam int DW = 32;
  localparam int HW = 16;
  localparam int CW = 5;
  localparam int LW = 3;
  localparam int ACW = 4;
  localparam int TW = 3;
  localparam int ZW = 2;
  localparam logic [1:0] WIDTH_16 = 2'h3;
  localparam logic [1:0] WIDTH_32 = 2'h1;
  localparam logic [CW-1:0] SYNC_PT = 5'h01;
  localparam logic [CW-1:0] ASYNC_PT = 5'h03;
  localparam logic [CW-1:0] ACT_BASE = 5'h01;
  localparam logic [CW-1:0] CNT_ONE = 5'h01;
  localparam logic [1:0] WB_LAST = 2'h2;
  localparam logic [1:0] WB_MAX = 2'h3;
  localparam logic [2:0] PER_FULL = 3'h1;
  localparam logic [2:0] PER_HALF = 3'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_BANK, ST_LEAD, ST_ACT, ST_TRAIL} zeb_st_t;
  typedef struct packed {
    logic [1:0] zone;
    logic wr;
    logic sz32;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } zeb_req_t;
  typedef struct packed {
    zeb_st_t st;
    logic [1:0] pc;
    logic [CW-1:0] rem;
    zeb_req_t [WBD-1:0] fifo;
    logic [1:0] head;
    logic [1:0] cnt;
    zeb_req_t cur;
    logic [1:0] last_zone;
    logic last_ok;
    logic rdy1;
    logic rdy2;
    logic [DW-1:0] din1;
    logic [DW-1:0] din2;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic xclk;
    logic ckoe;
    logic [ZONES-1:0] cs_n;
    logic rd_n;
    logic we0_n;
    logic we1_n;
    logic doe;
  } zeb_state_t;
  localparam zeb_state_t ZEB_RST = '{st: ST_IDLE, cs_n: '1, rd_n: 1'b1, we0_n: 1'b1,
    we1_n: 1'b1, xclk: 1'b1, ckoe: 1'b1, default: '0};
endpackage

// File: verification/zeb_mem_model.sv
module zeb_mem_model (
  input wire logic clk_in,
  input wire logic [zeb_pkg::ZONES-1:0] cs_n_in,
  input wire logic rd_n_in,
  input wire logic we0_n_in,
  input wire logic we1_n_in,
  input wire logic [zeb_pkg::AW-1:0] addr_in,
  input wire logic [zeb_pkg::DW-1:0] data_in,
  input wire logic [7:0] stall_in,
  output logic [zeb_pkg::DW-1:0] data_out,
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_q [256];
  logic [31:0] last_q = 32'h0;
  logic [7:0] wait_q = 8'h0;
  logic idle_q = 1'b1;
  logic sel, idle;
  assign sel = ~&cs_n_in;
  assign idle = rd_n_in & we0_n_in & we1_n_in;
  // selected read data, else a pattern that flips every cycle
  assign data_out = (sel && we0_n_in && we1_n_in) ? mem_q[addr_in[7:0]] : ~last_q;
  // pulled-up ready, low only while stretching
  assign ready_out = (wait_q == 8'h0);
  // memory starts all ones
  initial begin
    foreach (mem_q[i]) mem_q[i] = 32'hffffffff;
  end
  // lane writes and stretch counter
  always @(posedge clk_in) begin
    last_q <= data_out;
    idle_q <= idle;
    if (sel && !we0_n_in) mem_q[addr_in[7:0]][15:0] <= data_in[15:0];
    if (sel && !we1_n_in) mem_q[addr_in[7:0]][31:16] <= data_in[31:16];
    if (idle_q && !idle) wait_q <= stall_in;
    else if (wait_q != 8'h0) wait_q <= wait_q - 8'h1;
  end
endmodule // zeb_mem_model

// File: verification/testbench.sv
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic tfull = 1'b0, odiv = 1'b0, ckoff = 1'b0, wben = 1'b0, rv = 1'b0, rw = 1'b0;
  logic rs = 1'b0, csp = 1'b1, xst, done_f = 1'b0, got_rd = 1'b0;
  logic [1:0] wbdep = 2'h3, bzone = 2'h2, rz = 2'h0;
  logic [8:0] rdl = 9'h0b6, wrl = 9'h076, rdt = 9'h076, wrt = 9'h0f6;
  logic [11:0] rda = 12'h3ee, wra = 12'h2ee;
  logic [2:0] dbl = 3'h0, urdy = 3'h3, rsync = 3'h0, bcyc = 3'h0, cs;
  logic [5:0] wsel = 6'h17;
  logic [19:0] ra = 20'h0, xa, xad;
  logic [31:0] rdat = 32'h0, rdd, rdq, xdo, mdat, xdin;
  logic rdy, rdv, xclk, xoe, rdn, we0, we1, xdoe, mrdy, xprev;
  logic [7:0] stall = 8'h0;
  logic [1:0] lz [4] = '{2'h1, 2'h1, 2'h1, 2'h0};
  logic ls [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic [19:0] la [4] = '{20'h00040, 20'h00042, 20'h00043, 20'h00045};
  logic [1:0] le [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
  int fails = 0, total_checks = 0, ncs, nrd, nwe0, nwe1, idle, gap, xper, xcnt, stall_n, g0;
  // system clock and shared data wire
  always #50 clk_in = ~clk_in;
  assign xdin = xdoe ? xdo : mdat;
  zeb_external_interface dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .timing_clock_full_in(tfull), .output_clock_divide_select_in(odiv),
    .clock_output_disable_in(ckoff), .write_buffer_enable_in(wben),
    .write_buffer_depth_in(wbdep), .zone_rd_lead_in(rdl), .zone_rd_active_in(rda),
    .zone_rd_trail_in(rdt), .zone_wr_lead_in(wrl), .zone_wr_active_in(wra),
    .zone_wr_trail_in(wrt), .zone_timing_doubler_in(dbl), .zone_use_ready_in(urdy),
    .zone_ready_sync_in(rsync), .zone_width_select_in(wsel), .bank_zone_in(bzone),
    .bank_cycles_in(bcyc), .req_valid_in(rv), .req_ready_out(rdy), .req_zone_in(rz),
    .req_write_in(rw), .req_size32_in(rs), .req_addr_in(ra), .req_wdata_in(rdat),
    .rd_valid_out(rdv), .rd_data_out(rdd), .external_clock_output_out(xclk),
    .external_clock_output_oe_out(xoe), .zone_cs_n_out(cs), .read_strobe_n_out(rdn),
    .low_write_strobe_n_out(we0), .high_write_strobe_n_out(we1),
    .external_address_bus_out(xa), .external_data_bus_out(xdo),
    .external_data_bus_oe_out(xdoe), .external_data_bus_in(xdin),
    .external_ready_in(mrdy));
  zeb_mem_model mem_u (.clk_in(clk_in), .cs_n_in(cs), .rd_n_in(rdn), .we0_n_in(we0),
    .we1_n_in(we1), .addr_in(xa), .data_in(xdin), .stall_in(stall), .data_out(mdat),
    .ready_out(mrdy));
  // pin monitor: phase lengths, gaps, clock period, read data
  always @(posedge clk_in) begin
    if (!(&cs)) ncs++;
    if (!rdn) nrd++;
    if (!we0) nwe0++;
    if (!we1) nwe1++;
    if (&cs) idle++;
    if (csp && !(&cs)) begin
      gap = idle;
      xst = xclk;
      xad = xa;
    end
    if (!csp && (&cs)) begin
      done_f = 1'b1;
      idle = 0;
    end
    xcnt++;
    if (xclk === 1'b1 && xprev === 1'b0) begin
      xper = xcnt;
      xcnt = 0;
    end
    xprev = xclk;
    csp = &cs;
    if (rdv === 1'b1) begin
      got_rd = 1'b1;
      rdq = rdd;
    end
  end
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one request, held until taken; optionally wait for the access to end
  task automatic acc(input logic [1:0] z, input logic w, input logic s,
      input logic [19:0] a, input logic [31:0] d, input logic wait_end);
    int n;
    @(negedge clk_in);
    {ncs, nrd, nwe0, nwe1} = 128'h0;
    {done_f, got_rd} = 2'h0;
    {rv, rz, rw, rs, ra, rdat} = {1'b1, z, w, s, a, d};
    #1;
    n = 0;
    while (rdy !== 1'b1 && n < 3000) begin
      @(negedge clk_in);
      #1;
      n++;
    end
    stall_n = n;
    // a request never taken is a failure
    if (n >= 3000) begin
      fails++;
      $display("MISMATCH request taken expected 1 seen 0");
    end
    @(negedge clk_in);
    rv = 1'b0;
    n = 0;
    while (wait_end && !(done_f && (w || got_rd)) && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
    // an access that never ends is a failure
    if (n >= 3000) begin
      fails++;
      $display("MISMATCH access end expected 1 seen 0");
    end
  endtask
  // main sequence
  initial begin
    fork
      begin
        repeat (30000) @(posedge clk_in);
        fails++;
        conclude();
      end
    join_none
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    `CHK("selects", 3'h7, cs);
    `CHK("strobes", 3'h7, {rdn, we1, we0});
    acc(2'h0, 1'b1, 1'b0, 20'h00010, 32'h1234a5c3, 1'b1);
    `CHK("wr span", 54, ncs);
    `CHK("lead addr", 20'h00010, xad);
    `CHK("start rise", 1'b1, xst);
    `CHK("lanes16", 2'h1, {nwe1 != 0, nwe0 != 0});
    `CHK("no rd", 0, nrd);
    acc(2'h0, 1'b0, 1'b0, 20'h00010, 32'h0, 1'b1);
    `CHK("rd active", 30, nrd);
    `CHK("rd span", 54, ncs);
    `CHK("rd16", 32'h0000a5c3, rdq);
    `CHK("period", 4, xper);
    // settings come from ports, not the bus
    for (int i = 1; i < 3; i++) begin
      {tfull, odiv} = i[1:0];
      repeat (12) @(negedge clk_in);
      `CHK("period", 2, xper);
    end
    ckoff = 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK("clk oe", 1'b0, xoe);
    ckoff = 1'b0;
    repeat (3) @(negedge clk_in);
    `CHK("clk oe", 1'b1, xoe);
    for (int d = 0; d < 2; d++) begin
      dbl[2] = d[0];
      acc(2'h2, 1'b1, 1'b1, 20'h00020, 32'h13579bdf, 1'b1);
      `CHK("wr span", (1 << d) + (2 << d) + 1 + (3 << d), ncs);
      acc(2'h2, 1'b0, 1'b0, 20'h00020, 32'h0, 1'b1);
      `CHK("rd span", (2 << d) + (3 << d) + 1 + (1 << d), ncs);
      `CHK("rd active", (3 << d) + 1, nrd);
      `CHK("rd32", 32'h13579bdf, rdq);
    end
    for (int i = 0; i < 4; i++) begin
      acc(lz[i], 1'b1, ls[i], la[i], 32'hc0de0000, 1'b1);
      `CHK("lanes", le[i], {nwe1 != 0, nwe0 != 0});
    end
    stall = 8'h28;
    acc(2'h0, 1'b0, 1'b0, 20'h00010, 32'h0, 1'b1);
    `CHK("async stretch", 1'b1, nrd > 15);
    rsync[0] = 1'b1;
    acc(2'h0, 1'b1, 1'b0, 20'h00012, 32'h0, 1'b1);
    `CHK("sync wr stretch", 1'b1, nwe0 > 15);
    urdy[0] = 1'b0;
    acc(2'h0, 1'b0, 1'b0, 20'h00010, 32'h0, 1'b1);
    `CHK("ready ignored", 15, nrd);
    urdy[0] = 1'b1;
    stall = 8'h0;
    acc(2'h0, 1'b0, 1'b0, 20'h00010, 32'h0, 1'b1);
    `CHK("sync no stretch", 15, nrd);
    bcyc = 3'h7;
    acc(2'h1, 1'b0, 1'b0, 20'h00040, 32'h0, 1'b1);
    acc(2'h1, 1'b0, 1'b0, 20'h00040, 32'h0, 1'b1);
    g0 = gap;
    acc(2'h2, 1'b0, 1'b0, 20'h00020, 32'h0, 1'b1);
    `CHK("bank in", 1'b1, gap >= g0 + 6);
    acc(2'h1, 1'b0, 1'b0, 20'h00040, 32'h0, 1'b1);
    `CHK("bank out", 1'b1, gap >= g0 + 6);
    wben = 1'b1;
    for (int i = 0; i < 5; i++) begin
      acc(2'h1, 1'b1, 1'b1, 20'h00060, {28'h0, i[3:0]}, 1'b0);
      if (i < 3) `CHK("buffered", 0, stall_n);
    end
    `CHK("buffer full", 1'b1, stall_n > 0);
    acc(2'h1, 1'b0, 1'b0, 20'h00060, 32'h0, 1'b1);
    `CHK("write order", 32'h4, rdq);
    wben = 1'b0;
    acc(2'h1, 1'b1, 1'b1, 20'h00062, 32'h5, 1'b0);
    acc(2'h1, 1'b1, 1'b1, 20'h00064, 32'h6, 1'b0);
    `CHK("unbuffered", 1'b1, stall_n > 0);
    conclude();
  end
endmodule // testbench
